/* File: common/nco_defs.svh */
// Register map, field positions, reset values and the list of behaviours
// Contract
// RULE_01 - Pulse width field gives active time of 2^field input clock periods.
// RULE_02 - Pulse width only matters in pulse mode; ignored in toggle mode.
// RULE_03 - Software keeps pulse width shorter than the overflow period.
// RULE_04 - Source field: 0 system clock, 1 fast osc, 2..5 logic cells 1..4.
// RULE_05 - Software never programs the reserved source codes 6 and 7.
// RULE_06 - Accumulator spans three byte registers; upper bits 7-4 read zero.
// RULE_07 - Accumulator runs on the selected clock; reads show live value.
// RULE_08 - No atomic multi-byte access to the accumulator is provided.
// RULE_09 - Software writes the accumulator only while disabled.
// RULE_10 - Step value spans three byte registers; upper bits 7-4 read zero.
// RULE_11 - Low step write loads the step buffer on next falling input edge.
// RULE_12 - Software writes upper and high step bytes before the low byte.
// RULE_13 - Reset: step low byte is one, every other bit is zero.
// RULE_14 - Clock select bits 4-3 always read zero.
// RULE_15 - Each rising input edge adds the buffered step; bit 19 carry overflows.
// RULE_16 - Toggle mode: output toggles on every overflow.
// RULE_17 - Pulse mode: output active after overflow for the width; polarity sets level.
// RULE_18 - Each overflow sets a sticky flag until software clears it.
// RULE_19 - While disabled the accumulator holds and no events or output changes occur.
`ifndef NCO_DEFS_SVH
`define NCO_DEFS_SVH
// ----------------------------------------
// Byte addresses
// ----------------------------------------
`define NCO_OFF_CTRL   8'h00
`define NCO_OFF_CLK    8'h04
`define NCO_OFF_ACCL   8'h08
`define NCO_OFF_ACCH   8'h0C
`define NCO_OFF_ACCU   8'h10
`define NCO_OFF_STPL   8'h14
`define NCO_OFF_STPH   8'h18
`define NCO_OFF_STPU   8'h1C
`define NCO_OFF_FLAG   8'h20
// ----------------------------------------
// Field positions
// ----------------------------------------
`define NCO_CTL_EN     7
`define NCO_CTL_OUT    5
`define NCO_CTL_INV    4
`define NCO_CTL_PFM    0
`define NCO_CLK_PWS_HI 7
`define NCO_CLK_PWS_LO 5
`define NCO_CLK_CKS_HI 2
`define NCO_CLK_CKS_LO 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define NCO_RST_STEP   20'h00001
`define NCO_RST_ZERO20 20'h00000
`endif

/* File: common/nco_pkg.sv */
// Types shared by the oscillator block
package nco_pkg;
  typedef enum logic [2:0] {
    NCO_SRC_SYS, NCO_SRC_FAST, NCO_SRC_LC1, NCO_SRC_LC2,
    NCO_SRC_LC3, NCO_SRC_LC4, NCO_SRC_RSV6, NCO_SRC_RSV7
  } nco_src_e;
  typedef struct packed {
    logic       osc_enable;
    logic       output_invert;
    logic       pulse_mode_sel;
    logic [2:0] pulse_width_sel;
    logic [2:0] clock_source_sel;
  } nco_cfg_s;
endpackage

/* File: hw/nco_accumulator_regs.sv */
// Phase accumulator oscillator with APB byte registers
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "nco_defs.svh"
module nco_accumulator_regs
  import nco_pkg::*;
#(
  parameter int AW = 20
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        internal_fast_osc,
  input  wire logic        logic_cell_one_out,
  input  wire logic        logic_cell_two_out,
  input  wire logic        logic_cell_three_out,
  input  wire logic        logic_cell_four_out,
  output logic             output_state,
  output logic             overflow_flag
);
  // ----------------------------------------
  // Storage
  // ----------------------------------------
  nco_cfg_s        cfg_q;
  logic [AW-1:0]   accum_q;
  logic [AW-1:0]   step_q;
  logic [AW-1:0]   step_buffer_q;
  logic            step_pend_q;
  logic            src_prev_q;
  logic            tgl_q;
  logic            pulse_q;
  logic [6:0]      cnt_q;
  logic            flag_q;
  logic            rdy_q;
  logic [31:0]     rdata_q;

  logic            acc_sel;
  logic            wr_en;
  logic            rd_cap;
  logic            mapped;
  logic            src_cur;
  logic            rise;
  logic            fall;
  logic            tick;
  logic [AW:0]     sum;
  logic            ovf;
  logic            raw_out;
  logic [31:0]     rmux;

  // ----------------------------------------
  // APB slave: one wait state
  // ----------------------------------------
  // Decode of the nine mapped words
  always_comb begin
    case (paddr)
      `NCO_OFF_CTRL, `NCO_OFF_CLK, `NCO_OFF_ACCL, `NCO_OFF_ACCH, `NCO_OFF_ACCU,
      `NCO_OFF_STPL, `NCO_OFF_STPH, `NCO_OFF_STPU, `NCO_OFF_FLAG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign rd_cap  = psel & penable & ~rdy_q;
  assign wr_en   = psel & penable & rdy_q & pwrite & mapped;
  assign pready  = rdy_q;
  assign pslverr = rdy_q & ~mapped;
  assign prdata  = rdata_q;
  assign acc_sel = wr_en && (paddr == `NCO_OFF_ACCL || paddr == `NCO_OFF_ACCH ||
                             paddr == `NCO_OFF_ACCU);

  // Ready pulse after one wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= rd_cap;
    end
  end

  // Read mux; unimplemented bits are zero
  always_comb begin
    rmux = 32'h0000_0000;
    case (paddr)
      `NCO_OFF_CTRL: begin
        rmux[`NCO_CTL_EN]  = cfg_q.osc_enable;
        rmux[`NCO_CTL_OUT] = output_state;
        rmux[`NCO_CTL_INV] = cfg_q.output_invert;
        rmux[`NCO_CTL_PFM] = cfg_q.pulse_mode_sel;
      end
      `NCO_OFF_CLK: begin
        rmux[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO] = cfg_q.pulse_width_sel;
        rmux[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO] = cfg_q.clock_source_sel; // RULE_14
      end
      `NCO_OFF_ACCL: rmux[7:0] = accum_q[7:0]; // RULE_07
      `NCO_OFF_ACCH: rmux[7:0] = accum_q[15:8];
      `NCO_OFF_ACCU: rmux[3:0] = accum_q[19:16]; // RULE_06
      `NCO_OFF_STPL: rmux[7:0] = step_q[7:0];
      `NCO_OFF_STPH: rmux[7:0] = step_q[15:8];
      `NCO_OFF_STPU: rmux[3:0] = step_q[19:16]; // RULE_10
      `NCO_OFF_FLAG: rmux[0]   = flag_q;
      default:       rmux      = 32'h0000_0000;
    endcase
  end

  // Read data latched in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (rd_cap) begin
      rdata_q <= rmux;
    end
  end

  // Control and clock select bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= '0; // RULE_13
    end else if (wr_en && paddr == `NCO_OFF_CTRL) begin
      cfg_q.osc_enable     <= pwdata[`NCO_CTL_EN];
      cfg_q.output_invert  <= pwdata[`NCO_CTL_INV];
      cfg_q.pulse_mode_sel <= pwdata[`NCO_CTL_PFM];
    end else if (wr_en && paddr == `NCO_OFF_CLK) begin
      cfg_q.pulse_width_sel  <= pwdata[`NCO_CLK_PWS_HI:`NCO_CLK_PWS_LO];
      cfg_q.clock_source_sel <= pwdata[`NCO_CLK_CKS_HI:`NCO_CLK_CKS_LO];
    end
  end

  // Step bytes; a low byte write arms the buffer load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q <= `NCO_RST_STEP; // RULE_13
    end else if (wr_en) begin
      case (paddr)
        `NCO_OFF_STPL: step_q[7:0]   <= pwdata[7:0];
        `NCO_OFF_STPH: step_q[15:8]  <= pwdata[7:0];
        `NCO_OFF_STPU: step_q[19:16] <= pwdata[3:0]; // RULE_10
        default:       step_q        <= step_q;
      endcase
    end
  end

  // ----------------------------------------
  // Input clock selection and edge ticks
  // ----------------------------------------
  // Source mux; system clock ticks both edges every cycle
  always_comb begin
    src_cur = 1'b0;
    case (nco_src_e'(cfg_q.clock_source_sel)) // RULE_04
      NCO_SRC_FAST: src_cur = internal_fast_osc;
      NCO_SRC_LC1:  src_cur = logic_cell_one_out;
      NCO_SRC_LC2:  src_cur = logic_cell_two_out;
      NCO_SRC_LC3:  src_cur = logic_cell_three_out;
      NCO_SRC_LC4:  src_cur = logic_cell_four_out;
      default:      src_cur = 1'b0;
    endcase
  end

  // Previous level of the selected source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev_q <= 1'b0;
    end else begin
      src_prev_q <= src_cur;
    end
  end

  assign rise = (cfg_q.clock_source_sel == 3'h0) | (src_cur & ~src_prev_q);
  assign fall = (cfg_q.clock_source_sel == 3'h0) | (~src_cur & src_prev_q);
  assign tick = cfg_q.osc_enable & rise; // RULE_19
  assign sum  = {1'b0, accum_q} + {1'b0, step_buffer_q};
  assign ovf  = tick & sum[AW]; // RULE_15

  // ----------------------------------------
  // Step buffer and accumulator
  // ----------------------------------------
  // Buffer loads on next falling edge, or at once when disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_buffer_q <= `NCO_RST_STEP;
      step_pend_q   <= 1'b0;
    end else if (wr_en && paddr == `NCO_OFF_STPL) begin
      step_pend_q <= 1'b1;
    end else if (step_pend_q && (fall || !cfg_q.osc_enable)) begin
      step_buffer_q <= step_q; // RULE_11
      step_pend_q   <= 1'b0;
    end
  end

  // Accumulator; software bytes land without any interlock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      accum_q <= `NCO_RST_ZERO20;
    end else if (acc_sel) begin
      case (paddr) // RULE_08
        `NCO_OFF_ACCL: accum_q[7:0]   <= pwdata[7:0];
        `NCO_OFF_ACCH: accum_q[15:8]  <= pwdata[7:0];
        default:       accum_q[19:16] <= pwdata[3:0];
      endcase
    end else if (tick) begin
      accum_q <= sum[AW-1:0]; // RULE_15
    end
  end

  // ----------------------------------------
  // Output shaping
  // ----------------------------------------
  // Toggle on overflow in fixed duty mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgl_q <= 1'b0;
    end else if (ovf && !cfg_q.pulse_mode_sel) begin
      tgl_q <= ~tgl_q; // RULE_16
    end
  end

  // Pulse stretcher counting input clock periods
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_q <= 1'b0;
      cnt_q   <= 7'h00;
    end else if (ovf && cfg_q.pulse_mode_sel) begin
      pulse_q <= 1'b1; // RULE_17
      cnt_q   <= 7'((8'h01 << cfg_q.pulse_width_sel) - 8'h01); // RULE_01
    end else if (tick && pulse_q) begin
      if (cnt_q == 7'h00) begin
        pulse_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 7'h01;
      end
    end
  end

  assign raw_out      = cfg_q.pulse_mode_sel ? pulse_q : tgl_q; // RULE_02
  assign output_state = raw_out ^ cfg_q.output_invert; // RULE_17

  // Sticky overflow flag; write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else if (ovf) begin
      flag_q <= 1'b1; // RULE_18
    end else if (wr_en && paddr == `NCO_OFF_FLAG && pwdata[0]) begin
      flag_q <= 1'b0;
    end
  end

  assign overflow_flag = flag_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_pulse_start;
    ovf && cfg_q.pulse_mode_sel;
  endsequence

  sequence s_step_arm;
    wr_en && paddr == `NCO_OFF_STPL;
  endsequence

  a_acc_hold: assert property (!cfg_q.osc_enable && !acc_sel |=> $stable(accum_q)) // RULE_19
    else $error("accumulator moved while disabled");
  a_acc_add: assert property (tick && !acc_sel |=> accum_q == $past(sum[AW-1:0])) // RULE_15
    else $error("accumulator did not add step");
  a_flag_set: assert property (ovf |=> flag_q) // RULE_18
    else $error("overflow flag not set");
  a_fdc_toggle: assert property (ovf && !cfg_q.pulse_mode_sel |=> tgl_q != $past(tgl_q)) // RULE_16
    else $error("output did not toggle");
  a_pulse_width: assert property (s_pulse_start |=> pulse_q &&
      cnt_q == 7'((8'h01 << $past(cfg_q.pulse_width_sel)) - 8'h01)) // RULE_01
    else $error("pulse start or width wrong");
  a_pulse_end: assert property (tick && pulse_q && cnt_q == 7'h00 && !ovf |=> !pulse_q) // RULE_01
    else $error("pulse did not end");
  a_buf_load: assert property (step_pend_q && fall && !(wr_en && paddr == `NCO_OFF_STPL)
      |=> !step_pend_q && step_buffer_q == $past(step_q)) // RULE_11
    else $error("step buffer not loaded");
  a_clk_zero: assert property (rd_cap && paddr == `NCO_OFF_CLK // RULE_14
      |=> rdata_q[4:3] == 2'b00)
    else $error("clock select bits 4-3 not zero");
  a_upper_zero: assert property (rd_cap && (paddr == `NCO_OFF_ACCU || paddr == `NCO_OFF_STPU)
      |=> rdata_q[7:4] == 4'h0) // RULE_06
    else $error("upper byte high nibble not zero");
  a_fdc_out: assert property (!cfg_q.pulse_mode_sel && !ovf && !wr_en // RULE_02
      |=> $stable(output_state))
    else $error("pulse path leaked in toggle mode");
  // Flag, step buffer, idle and pulse counter checks
  a_flag_hold: assert property (flag_q // RULE_18
      && !(wr_en && paddr == `NCO_OFF_FLAG && pwdata[0]) |=> flag_q)
    else $error("overflow flag dropped without a clear");
  a_buf_arm: assert property (s_step_arm |=> step_pend_q) // RULE_11
    else $error("step buffer load not armed");
  a_buf_idle: assert property (!step_pend_q |=> $stable(step_buffer_q)) // RULE_11
    else $error("step buffer moved without a low byte write");
  a_off_quiet: assert property (!cfg_q.osc_enable && !wr_en |=> $stable(output_state)) // RULE_19
    else $error("output moved while disabled");
  a_pulse_count: assert property (tick && pulse_q && cnt_q != 7'h00 && !ovf // RULE_01
      |=> pulse_q && cnt_q == $past(cnt_q) - 7'h01)
    else $error("pulse counter did not step");
endmodule

/* File: sim/nco_sink_model.sv */
// Input clock sources and output monitor at the far side of the oscillator
`timescale 1ns/1ps
module nco_sink_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        output_state,
  output logic [4:0]       src_clk,
  output logic [15:0]      last_run,
  output logic [15:0]      n_edges
);
  int unsigned t_q;
  logic [15:0] cnt_q;
  logic        prev_q;
  // Free-running cycle count that the source clocks divide from
  always_ff @(posedge pclk) begin
    t_q <= t_q + 1;
  end
  // Fast source toggles each cycle, logic cell k every k+1 cycles
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      src_clk[i] = 1'(t_q / (i + 1));
    end
  end
  // Length in cycles of the last finished run of one output level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q   <= 1'b0;
      cnt_q    <= 16'h0000;
      last_run <= 16'h0000;
      n_edges  <= 16'h0000;
    end else if (output_state != prev_q) begin
      prev_q   <= output_state;
      last_run <= cnt_q;
      cnt_q    <= 16'h0001;
      n_edges  <= n_edges + 16'h0001;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule

/* File: sim/nco_accumulator_regs_tb.sv */
// Self-checking bench for the phase accumulator oscillator
`timescale 1ns/1ps
`include "nco_defs.svh"
module nco_accumulator_regs_tb;
  logic        pclk, presetn, psel, penable, pwrite, err_q;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, a1;
  logic        pready, pslverr, output_state, overflow_flag;
  logic [4:0]  src_clk;
  logic [15:0] last_run, n_edges, e1;
  int          n_fail, total_checks;
  int          per [6] = '{1, 2, 4, 6, 8, 10};

  nco_accumulator_regs u_nco_accumulator_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .internal_fast_osc(src_clk[0]),
    .logic_cell_one_out(src_clk[1]), .logic_cell_two_out(src_clk[2]),
    .logic_cell_three_out(src_clk[3]), .logic_cell_four_out(src_clk[4]),
    .output_state(output_state), .overflow_flag(overflow_flag)
  );
  nco_sink_model u_nco_sink_model (
    .pclk(pclk), .presetn(presetn), .output_state(output_state),
    .src_clk(src_clk), .last_run(last_run), .n_edges(n_edges)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, e, rdat);
  endtask
  // Upper and high bytes first, low byte commits the step
  task automatic wstep(input logic [19:0] s);
    wr(`NCO_OFF_STPU, {4'h0, s[19:16]});
    wr(`NCO_OFF_STPH, s[15:8]);
    wr(`NCO_OFF_STPL, s[7:0]);
  endtask
  task automatic do_reset();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // Wait for two entries into a level; one more edge lets the model log the run before
  task automatic wait_run(input logic lvl);
    repeat (2) begin
      while (output_state === lvl) begin
        @(negedge pclk);
      end
      while (output_state !== lvl) begin
        @(negedge pclk);
      end
    end
    @(negedge pclk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    do_reset();
    for (int a = 0; a <= 32; a += 4) begin
      rd("reset", 8'(a), 32'((a == `NCO_OFF_STPL) ? 1 : 0));
    end
    wr(`NCO_OFF_CLK, 8'hFD);
    rd("clk", `NCO_OFF_CLK, 32'h000000E5);
    wr(`NCO_OFF_ACCU, 8'hFF);
    rd("accu", `NCO_OFF_ACCU, 32'h0000000F);
    wr(`NCO_OFF_ACCL, 8'h5A);
    rd("accl", `NCO_OFF_ACCL, 32'h0000005A);
    wr(`NCO_OFF_STPU, 8'hFF);
    rd("stpu", `NCO_OFF_STPU, 32'h0000000F);
    wr(8'h24, 8'h55);
    chk("err", 32'h1, 32'(err_q));
    rd("unmapped", 8'h24, 32'h0);
  endtask
  // Each source, width field set but ignored in toggle mode
  task automatic t_src();
    for (int i = 0; i < 6; i++) begin
      do_reset();
      wstep(20'h80000);
      wr(`NCO_OFF_CLK, {5'b11100, 3'(i)});
      wr(`NCO_OFF_CTRL, 8'h80);
      wait_run(1'b0);
      chk("period", 32'(2 * per[i]), 32'(last_run));
    end
  endtask
  // Active run length per width code, polarity alternating
  task automatic t_pulse();
    for (int p = 0; p < 8; p++) begin
      do_reset();
      wstep(20'h01000);
      wr(`NCO_OFF_CLK, {3'(p), 5'b00000});
      wr(`NCO_OFF_CTRL, p[0] ? 8'h91 : 8'h81);
      wait_run(p[0]);
      chk("width", 32'(1 << p), 32'(last_run));
    end
  endtask
  task automatic t_buf();
    do_reset();
    wr(`NCO_OFF_CTRL, 8'h80);
    apb(1'b0, `NCO_OFF_ACCL, 8'h00);
    a1 = rdat;
    apb(1'b0, `NCO_OFF_ACCL, 8'h00);
    chk("live", 32'h1, 32'(a1 !== rdat));
    wstep(20'h80000);
    wait_run(1'b0);
    chk("period", 32'h2, 32'(last_run));
    wr(`NCO_OFF_STPU, 8'h04);
    wait_run(1'b0);
    chk("unbuffered", 32'h2, 32'(last_run));
    wr(`NCO_OFF_STPL, 8'h00);
    wait_run(1'b0);
    chk("committed", 32'h4, 32'(last_run));
    wr(`NCO_OFF_CTRL, 8'h00);
    rd("flag", `NCO_OFF_FLAG, 32'h1);
    chk("flag pin", 32'h1, 32'(overflow_flag));
    e1 = n_edges;
    apb(1'b0, `NCO_OFF_ACCL, 8'h00);
    a1 = rdat;
    repeat (20) @(posedge pclk);
    rd("hold", `NCO_OFF_ACCL, a1);
    chk("edges", 32'(e1), 32'(n_edges));
    wr(`NCO_OFF_FLAG, 8'h01);
    rd("flag clr", `NCO_OFF_FLAG, 32'h0);
    chk("flag pin", 32'h0, 32'(overflow_flag));
  endtask

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  task automatic give_verdict();
    if (n_fail == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Clock generator
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Watchdog well beyond the expected run length
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    give_verdict();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h00000000;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_src();
    t_pulse();
    t_buf();
    give_verdict();
  end
endmodule
